// ---- core/exs_consts.svh ----
// Offsets, status-register bit positions, reset values and step sizes of the
// extended stack and shift execution unit.
// Assumes byte addressing on the Avalon-MM slave and 16-bit words on the memory side.
`ifndef EXS_CONSTS_SVH
`define EXS_CONSTS_SVH

`define EXS_OFF_CMD 8'h00
`define EXS_OFF_OPND 8'h04
`define EXS_OFF_STAT 8'h08
`define EXS_OFF_REGS 8'h40
`define EXS_REGS_MASK 8'hC0

`define EXS_R_PC 4'h0
`define EXS_R_SP 4'h1
`define EXS_R_SR 4'h2

`define EXS_SR_C 0
`define EXS_SR_Z 1
`define EXS_SR_N 2
`define EXS_SR_GIE 3
`define EXS_SR_CORE_HALT_BIT 4
`define EXS_SR_OSCILLATOR_OFF_BIT 5
`define EXS_SR_V 8

`define EXS_REG_RST 20'h0_0000
`define EXS_STEP_A 20'h0_0004
`define EXS_STEP_W 20'h0_0002
`define EXS_STEP_B 20'h0_0001

`define EXS_OVF_A_LO 20'h4_0000
`define EXS_OVF_A_HI 20'hC_0000
`define EXS_OVF_W_LO 16'h4000
`define EXS_OVF_W_HI 16'hC000
`define EXS_OVF_B_LO 8'h40
`define EXS_OVF_B_HI 8'hC0

`endif

// ---- core/exs_exec_core.sv ----
// Execution unit for multi and single push/pop, left shifts and short address moves.
// Assumes a 16-bit data memory with Avalon-style waitrequest on the same clock.
// Notes on behaviour
// - Short address move carries only a 16-bit signed index, sign-extended.
// - Address-word multi_pop restores 20 bits from two words, stack pointer plus four each.
// - multi_pop fills registers upward from dest minus n plus one to dest.
// - Word multi_pop takes one word, stack pointer plus two, clears bits 19:16.
// - Address-word multi_push: stack pointer minus four, upper bits at higher address.
// - multi_push saves n registers from dest downward; saved registers stay unchanged.
// - Word multi_push stores low 16 bits, stack pointer minus two each.
// - Push and pop leave N, Z, C, V alone unless status register is restored.
// - single_pop copies stack_top item, then stack pointer plus two or four.
// - single_pop destination: register, indexed, symbolic or absolute, full 20-bit space.
// - single_push lowers stack pointer by two or four before any memory write.
// - single_push then writes source to new stack_top; seven source modes.
// - Multi ops and single_push execute from one command, no extension word.
// - multi_shift_left shifts by 1 to 4, zero fill; word form clears 19:16.
// - multi_shift_left carry gets original bit MSB minus n plus one; V undefined.
// - multi_shift_left N from bit 19 or 15; Z only for zero result.
// - shift_left_ext shifts one left, top bit to carry, zero in; sets N, Z.
// - shift_left_ext sets V for operand in the 4..C quarter range per size.
// - Mode bits GLOBAL_INTERRUPT_ENABLE, core halt, oscillator off untouched except status restore.
`timescale 1ns/1ns
`include "exs_consts.svh"

module exs_exec_core import exs_pkg::*; (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Avalon-MM register slave
	input wire logic [7:0] avAddress,
	input wire logic avRead,
	input wire logic avWrite,
	input wire logic [31:0] avWritedata,
	output logic [31:0] avReaddata,
	output logic avWaitrequest,
	// Data memory master, byte address, 16-bit words
	output logic [19:0] memAddress,
	output logic [15:0] memWritedata,
	output logic [1:0] memByteenable,
	output logic memRead,
	output logic memWrite,
	input wire logic [15:0] memReaddata,
	input wire logic memWaitrequest
);
	logic [1:0] rstSync_reg;
	logic sysRstN;
	exs_state_t st_reg;
	exs_state_t st_next;
	exs_cmd_t wCmd;
	logic busy;
	logic cmdAccept;

	function automatic exs_mem_t memReq(input logic [19:0] a, input logic [15:0] d, input logic [1:0] be,
		input logic rd, input logic wr);
		exs_mem_t m;
		m.addr = a;
		m.wdata = d;
		m.be = be;
		m.rd = rd;
		m.wr = wr;
		return m;
	endfunction

	function automatic logic [19:0] stepOf(input exs_size_t sz);
		return (sz == SZ_A) ? `EXS_STEP_A : `EXS_STEP_W;
	endfunction

	function automatic logic [19:0] effAddr(input exs_mode_t md, input logic [19:0] base, input logic [19:0] pc,
		input logic [19:0] op);
		unique case (md)
			M_IDX: return base + op;
			M_SYM: return pc + op;
			M_ABS: return op;
			default: return base;
		endcase
	endfunction

	function automatic logic cmdLegal(input exs_cmd_t c);
		logic ok;
		ok = (c.size != 2'h3) && (c.op != 3'h7) && (c.mode != 3'h7);
		if ((c.op == OP_SPOP || c.op == OP_SHIFTX) && c.mode > M_ABS) begin
			ok = 1'b0;
		end
		if (c.op == OP_MSHIFT && (c.cntM1[3:2] != 2'h0 || c.size == SZ_B)) begin
			ok = 1'b0;
		end
		if ((c.op == OP_MPUSH || c.op == OP_MPOP) && c.size == SZ_B) begin
			ok = 1'b0;
		end
		if (c.op == OP_AMOVE && c.mode != M_IDX && c.mode != M_SYM) begin
			ok = 1'b0;
		end
		return ok;
	endfunction

	function automatic exs_shres_t shiftOne(input exs_size_t sz, input logic [19:0] x);
		exs_shres_t h;
		h = '0;
		unique case (sz)
			SZ_B: begin
				h.res = {12'h000, x[6:0], 1'b0};
				h.c = x[7];
				h.n = x[6];
				h.v = (x[7:0] >= `EXS_OVF_B_LO) && (x[7:0] < `EXS_OVF_B_HI);
			end
			SZ_W: begin
				h.res = {4'h0, x[14:0], 1'b0};
				h.c = x[15];
				h.n = x[14];
				h.v = (x[15:0] >= `EXS_OVF_W_LO) && (x[15:0] < `EXS_OVF_W_HI);
			end
			default: begin
				h.res = {x[18:0], 1'b0};
				h.c = x[19];
				h.n = x[18];
				h.v = (x >= `EXS_OVF_A_LO) && (x < `EXS_OVF_A_HI);
			end
		endcase
		h.z = (h.res == 20'h0_0000);
		return h;
	endfunction

	function automatic exs_shres_t shiftMulti(input logic aw, input logic [1:0] k, input logic [19:0] x);
		exs_shres_t h;
		logic [23:0] t;
		h = '0;
		t = {4'h0, x} << ({1'b0, k} + 3'h1);
		if (aw) begin
			h.res = t[19:0];
			h.c = t[20];
			h.n = t[19];
		end else begin
			h.res = {4'h0, t[15:0]};
			h.c = t[16];
			h.n = t[15];
		end
		h.z = (h.res == 20'h0_0000);
		return h;
	endfunction

	// Only the arithmetic flags move; GLOBAL_INTERRUPT_ENABLE and the power bits are never written here
	function automatic logic [19:0] putFlags(input logic [19:0] sr, input exs_shres_t h, input logic withV);
		logic [19:0] o;
		o = sr;
		o[`EXS_SR_C] = h.c;
		o[`EXS_SR_Z] = h.z;
		o[`EXS_SR_N] = h.n;
		if (withV) begin
			o[`EXS_SR_V] = h.v;
		end
		return o;
	endfunction

	function automatic exs_state_t goIdle(input exs_state_t s);
		exs_state_t o;
		o = s;
		o.fsm = ST_IDLE;
		o.mem = '0;
		return o;
	endfunction

	function automatic exs_state_t beginRead(input exs_state_t s, input logic [19:0] a);
		exs_state_t o;
		o = s;
		o.addr = a;
		o.fsm = ST_RD_LO;
		o.mem = memReq(a, 16'h0000, 2'h3, 1'b1, 1'b0);
		return o;
	endfunction

	// 20-bit items go upper word first, at the higher address
	function automatic exs_state_t beginWrite(input exs_state_t s, input logic [19:0] a, input logic [19:0] v);
		exs_state_t o;
		o = s;
		o.addr = a;
		o.value = v;
		if (s.cmd.size == SZ_A) begin
			o.fsm = ST_W_HI;
			o.mem = memReq(a + `EXS_STEP_W, {12'h000, v[19:16]}, 2'h3, 1'b0, 1'b1);
		end else if (s.cmd.size == SZ_B) begin
			o.fsm = ST_W_LO;
			o.mem = memReq(a, {v[7:0], v[7:0]}, a[0] ? 2'h2 : 2'h1, 1'b0, 1'b1);
		end else begin
			o.fsm = ST_W_LO;
			o.mem = memReq(a, v[15:0], 2'h3, 1'b0, 1'b1);
		end
		return o;
	endfunction

	function automatic exs_state_t afterRead(input exs_state_t s, input logic [19:0] v);
		exs_state_t o;
		logic [19:0] spn;
		exs_shres_t h;
		o = s;
		h = '0;
		unique case (s.cmd.op)
			OP_MPOP: begin
				spn = s.regs[`EXS_R_SP] + stepOf(s.cmd.size);
				o.regs[s.cur] = v;
				o.regs[`EXS_R_SP] = spn;
				if (s.cnt != 4'h0) begin
					o.cnt = s.cnt - 4'h1;
					o.cur = s.cur + 4'h1;
					o = beginRead(o, spn);
				end else begin
					o = goIdle(o);
				end
			end
			OP_SPOP: begin
				o.regs[`EXS_R_SP] = s.regs[`EXS_R_SP] + stepOf(s.cmd.size);
				if (s.cmd.mode == M_REG) begin
					o.regs[s.cmd.regNum] = v;
					o = goIdle(o);
				end else begin
					o = beginWrite(o, effAddr(s.cmd.mode, o.regs[s.cmd.regNum], o.regs[`EXS_R_PC], s.opnd), v);
				end
			end
			OP_SPUSH: begin
				spn = s.regs[`EXS_R_SP] - stepOf(s.cmd.size);
				o.regs[`EXS_R_SP] = spn;
				o = beginWrite(o, spn, v);
			end
			OP_SHIFTX: begin
				h = shiftOne(s.cmd.size, v);
				o.regs[`EXS_R_SR] = putFlags(s.regs[`EXS_R_SR], h, 1'b1);
				o = beginWrite(o, s.addr, h.res);
			end
			default: o = goIdle(o);
		endcase
		return o;
	endfunction

	function automatic exs_state_t afterWrite(input exs_state_t s);
		exs_state_t o;
		logic [19:0] spn;
		o = s;
		if (s.cmd.op == OP_MPUSH && s.cnt != 4'h0) begin
			spn = s.regs[`EXS_R_SP] - stepOf(s.cmd.size);
			o.cnt = s.cnt - 4'h1;
			o.cur = s.cur - 4'h1;
			o.regs[`EXS_R_SP] = spn;
			o = beginWrite(o, spn, s.regs[o.cur]);
		end else begin
			o = goIdle(o);
		end
		return o;
	endfunction

	function automatic logic [31:0] readMux(input exs_state_t s, input logic [7:0] a, input logic bsy);
		if ((a & `EXS_REGS_MASK) == `EXS_OFF_REGS) begin
			return {12'h000, s.regs[a[5:2]]};
		end
		unique case (a)
			`EXS_OFF_CMD: return s.cmd;
			`EXS_OFF_OPND: return {12'h000, s.opnd};
			`EXS_OFF_STAT: return {26'h000_0000, s.fsm, s.shortOk, s.err, bsy};
			default: return 32'h0000_0000;
		endcase
	endfunction

	// Reset leaves through two flops so release is clean against the clock
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rstSync_reg <= 2'h0;
		end else begin
			rstSync_reg <= {rstSync_reg[0], 1'b1};
		end
	end
	assign sysRstN = rstSync_reg[1];

	assign busy = (st_reg.fsm != ST_IDLE);
	assign wCmd = exs_cmd_t'(avWritedata);
	assign cmdAccept = avWrite && !busy && (avAddress == `EXS_OFF_CMD);
	// Reads answer one cycle late from a flop; writes stall while an instruction runs
	assign avWaitrequest = (avRead && !st_reg.rdHold) || (avWrite && busy);
	assign avReaddata = st_reg.rdData;
	assign memAddress = st_reg.mem.addr;
	assign memWritedata = st_reg.mem.wdata;
	assign memByteenable = st_reg.mem.be;
	assign memRead = st_reg.mem.rd;
	assign memWrite = st_reg.mem.wr;

	always_comb begin
		logic [19:0] v;
		logic [19:0] spn;
		logic [19:0] tgt;
		logic [7:0] lane;
		exs_shres_t h;
		v = 20'h0_0000;
		spn = 20'h0_0000;
		tgt = 20'h0_0000;
		lane = 8'h00;
		h = '0;
		st_next = st_reg;
		st_next.rdHold = avRead && !st_reg.rdHold;
		if (avRead && !st_reg.rdHold) begin
			st_next.rdData = readMux(st_reg, avAddress, busy);
		end
		if (avWrite && !busy) begin
			if ((avAddress & `EXS_REGS_MASK) == `EXS_OFF_REGS) begin
				st_next.regs[avAddress[5:2]] = avWritedata[19:0];
			end else if (avAddress == `EXS_OFF_OPND) begin
				st_next.opnd = avWritedata[19:0];
			end
		end
		if (cmdAccept) begin
			// The whole instruction comes in one command word, no prefix word
			st_next.cmd = wCmd;
			st_next.err = !cmdLegal(wCmd);
			st_next.cur = wCmd.regNum;
			st_next.cnt = wCmd.cntM1;
			if (cmdLegal(wCmd)) begin
				unique case (wCmd.op)
					OP_MPUSH: begin
						spn = st_reg.regs[`EXS_R_SP] - stepOf(wCmd.size);
						st_next.regs[`EXS_R_SP] = spn;
						st_next = beginWrite(st_next, spn, st_reg.regs[wCmd.regNum]);
					end
					OP_MPOP: begin
						st_next.cur = wCmd.regNum - wCmd.cntM1;
						st_next = beginRead(st_next, st_reg.regs[`EXS_R_SP]);
					end
					OP_SPUSH: begin
						if (wCmd.mode == M_INC) begin
							st_next.regs[wCmd.regNum] = st_reg.regs[wCmd.regNum] +
								((wCmd.size == SZ_B) ? `EXS_STEP_B : stepOf(wCmd.size));
						end
						if (wCmd.mode == M_REG || wCmd.mode == M_IMM) begin
							v = (wCmd.mode == M_REG) ? st_reg.regs[wCmd.regNum] : st_reg.opnd;
							spn = st_reg.regs[`EXS_R_SP] - stepOf(wCmd.size);
							st_next.regs[`EXS_R_SP] = spn;
							st_next = beginWrite(st_next, spn, v);
						end else begin
							tgt = effAddr(wCmd.mode, st_reg.regs[wCmd.regNum], st_reg.regs[`EXS_R_PC], st_reg.opnd);
							st_next = beginRead(st_next, tgt);
						end
					end
					OP_SPOP: st_next = beginRead(st_next, st_reg.regs[`EXS_R_SP]);
					OP_MSHIFT: begin
						h = shiftMulti(wCmd.size == SZ_A, wCmd.cntM1[1:0], st_reg.regs[wCmd.regNum]);
						st_next.regs[wCmd.regNum] = h.res;
						// V is left as it was: its value is undefined after this shift
						st_next.regs[`EXS_R_SR] = putFlags(st_next.regs[`EXS_R_SR], h, 1'b0);
					end
					OP_SHIFTX: begin
						if (wCmd.mode == M_REG) begin
							h = shiftOne(wCmd.size, st_reg.regs[wCmd.regNum]);
							st_next.regs[wCmd.regNum] = h.res;
							st_next.regs[`EXS_R_SR] = putFlags(st_next.regs[`EXS_R_SR], h, 1'b1);
						end else begin
							tgt = effAddr(wCmd.mode, st_reg.regs[wCmd.regNum], st_reg.regs[`EXS_R_PC], st_reg.opnd);
							st_next = beginRead(st_next, tgt);
						end
					end
					OP_AMOVE: begin
						// Index above 16 bits is dropped; shortOk tells software if that was lossless
						st_next.shortOk = (st_reg.opnd[19:15] == 5'h00) || (st_reg.opnd[19:15] == 5'h1F);
						tgt = ((wCmd.mode == M_SYM) ? st_reg.regs[`EXS_R_PC] : st_reg.regs[wCmd.reg2]) +
							{{4{st_reg.opnd[15]}}, st_reg.opnd[15:0]};
						st_next.cmd.size = SZ_A;
						st_next = beginWrite(st_next, tgt, st_reg.regs[wCmd.regNum]);
					end
					default: st_next.err = 1'b1;
				endcase
			end
		end
		if (busy && !memWaitrequest) begin
			lane = st_reg.addr[0] ? memReaddata[15:8] : memReaddata[7:0];
			unique case (st_reg.fsm)
				ST_RD_LO: begin
					if (st_reg.cmd.size == SZ_A) begin
						st_next.value = {4'h0, memReaddata};
						st_next.fsm = ST_RD_HI;
						st_next.mem = memReq(st_reg.addr + `EXS_STEP_W, 16'h0000, 2'h3, 1'b1, 1'b0);
					end else if (st_reg.cmd.size == SZ_B) begin
						st_next = afterRead(st_next, {12'h000, lane});
					end else begin
						st_next = afterRead(st_next, {4'h0, memReaddata});
					end
				end
				ST_RD_HI: st_next = afterRead(st_next, {memReaddata[3:0], st_reg.value[15:0]});
				ST_W_HI: begin
					st_next.fsm = ST_W_LO;
					st_next.mem = memReq(st_reg.addr, st_reg.value[15:0], 2'h3, 1'b0, 1'b1);
				end
				ST_W_LO: st_next = afterWrite(st_next);
				default: st_next = goIdle(st_next);
			endcase
		end
	end

	always_ff @(posedge clock or negedge sysRstN) begin
		if (!sysRstN) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	default clocking @(posedge clock); endclocking
	default disable iff (!sysRstN);

	logic [4:0] mshPos;
	assign mshPos = ((wCmd.size == SZ_A) ? 5'd19 : 5'd15) - {3'h0, wCmd.cntM1[1:0]};
	logic popDone;
	assign popDone = !memWaitrequest && st_reg.cmd.op == OP_MPOP &&
		((st_reg.fsm == ST_RD_LO && st_reg.cmd.size != SZ_A) || st_reg.fsm == ST_RD_HI);

	spBeforeWrite_a: assert property (st_reg.fsm == ST_W_LO && st_reg.cmd.op == OP_SPUSH |->
		memAddress == st_reg.regs[`EXS_R_SP]) else $error("push wrote before stack pointer moved");
	upperNibble_a: assert property (st_reg.fsm == ST_W_HI |->
		memWritedata[15:4] == 12'h000 && memAddress == st_reg.addr + 20'h0_0002)
		else $error("upper stack word malformed");
	pushDown_a: assert property (st_reg.fsm == ST_W_LO && !memWaitrequest && st_reg.cmd.op == OP_MPUSH &&
		st_reg.cnt != 4'h0 |=> st_reg.cur == $past(st_reg.cur) - 4'h1 ##0 st_reg.fsm != ST_IDLE)
		else $error("multi push order wrong");
	popAscend_a: assert property (popDone && st_reg.cnt != 4'h0 |=>
		st_reg.cur == $past(st_reg.cur) + 4'h1 ##0 st_reg.fsm == ST_RD_LO) else $error("multi pop order wrong");
	popWordClear_a: assert property (popDone && st_reg.cmd.size == SZ_W && st_reg.cur != `EXS_R_SP |=>
		st_reg.regs[$past(st_reg.cur)][19:16] == 4'h0) else $error("word pop kept upper bits");
	spPopStep_a: assert property (!memWaitrequest && st_reg.fsm == ST_RD_LO && st_reg.cmd.op == OP_SPOP &&
		st_reg.cmd.size != SZ_A && !(st_reg.cmd.mode == M_REG && st_reg.cmd.regNum == `EXS_R_SP) |=>
		st_reg.regs[`EXS_R_SP] == $past(st_reg.regs[`EXS_R_SP]) + 20'h0_0002) else $error("pop step wrong");
	flagsKept_a: assert property (busy && st_reg.cmd.op inside {OP_MPUSH, OP_SPUSH, OP_AMOVE} |=>
		$stable(st_reg.regs[`EXS_R_SR])) else $error("push changed status register");
	shiftCarry_a: assert property (cmdAccept && wCmd.op == OP_MSHIFT && cmdLegal(wCmd) &&
		wCmd.regNum != `EXS_R_SR |=> st_reg.regs[`EXS_R_SR][`EXS_SR_C] == $past(st_reg.regs[wCmd.regNum][mshPos]))
		else $error("multi shift carry wrong");
	mshWordClear_a: assert property (cmdAccept && wCmd.op == OP_MSHIFT && wCmd.size == SZ_W &&
		cmdLegal(wCmd) && wCmd.regNum != `EXS_R_SR |=> st_reg.regs[$past(wCmd.regNum)][19:16] == 4'h0 &&
		st_reg.regs[`EXS_R_SR][`EXS_SR_N] == st_reg.regs[$past(wCmd.regNum)][15])
		else $error("word multi shift result wrong");
	rlaOverflow_a: assert property (cmdAccept && wCmd.op == OP_SHIFTX && wCmd.mode == M_REG &&
		wCmd.size == SZ_W && wCmd.regNum != `EXS_R_SR |=> st_reg.regs[`EXS_R_SR][`EXS_SR_V] ==
		$past(st_reg.regs[wCmd.regNum][15:0] >= 16'h4000 && st_reg.regs[wCmd.regNum][15:0] < 16'hC000))
		else $error("shift overflow flag wrong");

	pushDone_c: cover property (st_reg.cmd.op == OP_MPUSH && st_reg.cmd.size == SZ_A && st_reg.fsm == ST_W_LO &&
		!memWaitrequest && st_reg.cnt == 4'h0);
	popDone_c: cover property (popDone && st_reg.cnt == 4'h0 && st_reg.cmd.size == SZ_A);
	shiftMem_c: cover property (st_reg.cmd.op == OP_SHIFTX && st_reg.fsm == ST_W_LO &&
		st_reg.regs[`EXS_R_SR][`EXS_SR_V]);
endmodule

// ---- core/exs_pkg.sv ----
// Types of the extended stack and shift execution unit.
// Opcode, size, mode and state encodings are given here, not in the constants header.
package exs_pkg;
	typedef enum logic [2:0] {
		OP_MPUSH = 3'h0, OP_MPOP = 3'h1, OP_SPUSH = 3'h2, OP_SPOP = 3'h3,
		OP_MSHIFT = 3'h4, OP_SHIFTX = 3'h5, OP_AMOVE = 3'h6
	} exs_op_t;
	typedef enum logic [1:0] {SZ_W = 2'h0, SZ_B = 2'h1, SZ_A = 2'h2} exs_size_t;
	typedef enum logic [2:0] {
		M_REG = 3'h0, M_IDX = 3'h1, M_SYM = 3'h2, M_ABS = 3'h3,
		M_IND = 3'h4, M_INC = 3'h5, M_IMM = 3'h6
	} exs_mode_t;
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0, ST_RD_LO = 3'h1, ST_RD_HI = 3'h3, ST_W_HI = 3'h2, ST_W_LO = 3'h6
	} exs_fsm_t;
	typedef struct packed {
		logic [10:0] rsvd;
		logic [3:0] reg2;
		logic [3:0] regNum;
		logic [3:0] cntM1;
		logic pad;
		exs_mode_t mode;
		exs_size_t size;
		exs_op_t op;
	} exs_cmd_t;
	typedef struct packed {
		logic [19:0] addr;
		logic [15:0] wdata;
		logic [1:0] be;
		logic rd;
		logic wr;
	} exs_mem_t;
	typedef struct packed {
		logic [19:0] res;
		logic c;
		logic z;
		logic n;
		logic v;
	} exs_shres_t;
	typedef struct packed {
		exs_fsm_t fsm;
		logic [15:0][19:0] regs;
		exs_cmd_t cmd;
		logic [19:0] opnd;
		logic [19:0] addr;
		logic [19:0] value;
		logic [3:0] cur;
		logic [3:0] cnt;
		logic err;
		logic shortOk;
		logic rdHold;
		logic [31:0] rdData;
		exs_mem_t mem;
	} exs_state_t;
endpackage

// ---- testbench/exs_mem_model.sv ----
// Word-wide data memory holding the stack, as an Avalon-style slave.
// Assumes byte addresses below 0x800; slow adds one wait cycle per access.
`timescale 1ns/1ns
module exs_mem_model (
	// Clock and pacing
	input wire logic clock,
	input wire logic slow,
	// Memory slave
	input wire logic [19:0] memAddress,
	input wire logic [15:0] memWritedata,
	input wire logic [1:0] memByteenable,
	input wire logic memRead,
	input wire logic memWrite,
	output logic [15:0] memReaddata,
	output logic memWaitrequest
);
	logic [15:0] mem [0:1023];
	logic waited = 1'b0;
	wire [9:0] idx = memAddress[10:1];
	assign memWaitrequest = slow && (memRead || memWrite) && !waited;
	// Idle bus shows inverted data so a stale sample cannot pass
	assign memReaddata = memRead ? mem[idx] : ~mem[idx];
	always_ff @(posedge clock) begin
		waited <= slow && (memRead || memWrite) && !waited;
		if (memWrite && !memWaitrequest) begin
			if (memByteenable[0]) mem[idx][7:0] <= memWritedata[7:0];
			if (memByteenable[1]) mem[idx][15:8] <= memWritedata[15:8];
		end
	end
endmodule

// ---- testbench/tb_ext_stack_and_shift_exec.sv ----
// Self-checking bench for the stack and shift execution unit.
// Assumes the memory model on the data side and Avalon register access.
`timescale 1ns/1ns
`include "exs_consts.svh"
module tb_ext_stack_and_shift_exec import exs_pkg::*; ;
	logic clock = 0, rst_n = 0, avRead = 0, avWrite = 0, slow = 0;
	logic [7:0] avAddress = '0;
	logic [31:0] avWritedata = '0, avReaddata;
	logic avWaitrequest, memRead, memWrite, memWaitrequest;
	logic [19:0] memAddress;
	logic [15:0] memWritedata, memReaddata;
	logic [1:0] memByteenable;
	int n_fail = 0, compares = 0, cyc = 0;
	exs_exec_core u_dut (.clock(clock), .rst_n(rst_n), .avAddress(avAddress), .avRead(avRead), .avWrite(avWrite),
		.avWritedata(avWritedata), .avReaddata(avReaddata), .avWaitrequest(avWaitrequest),
		.memAddress(memAddress), .memWritedata(memWritedata), .memByteenable(memByteenable),
		.memRead(memRead), .memWrite(memWrite), .memReaddata(memReaddata), .memWaitrequest(memWaitrequest));
	exs_mem_model u_mem (.clock(clock), .slow(slow), .memAddress(memAddress), .memWritedata(memWritedata),
		.memByteenable(memByteenable), .memRead(memRead), .memWrite(memWrite), .memReaddata(memReaddata),
		.memWaitrequest(memWaitrequest));
	initial forever #10 clock = ~clock;
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// Whole run needs under a thousand cycles
	always @(posedge clock) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			wrap_up();
		end
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		avAddress <= a;
		avWritedata <= d;
		avWrite <= wr;
		avRead <= !wr;
		do @(posedge clock); while (avWaitrequest !== 1'b0);
		q = avReaddata;
		avWrite <= 0;
		avRead <= 0;
		@(posedge clock);
	endtask
	function automatic logic [7:0] ra(input int r);
		return `EXS_OFF_REGS + 8'(r * 4);
	endfunction
	function automatic logic [19:0] pv(input int i);
		return {4'(i + 8), 12'h5A0, 4'(i)};
	endfunction
	function automatic logic [15:0] mw(input logic [19:0] a);
		return u_mem.mem[a[10:1]];
	endfunction
	function automatic logic [31:0] cm(exs_op_t o, exs_size_t s, exs_mode_t m, int n, int r, int r2 = 0);
		return {11'h0, 4'(r2), 4'(r), 4'(n - 1), 1'b0, m, s, o};
	endfunction
	task automatic wreg(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1, a, d, q);
	endtask
	task automatic ckr(input int r, input logic [19:0] e);
		logic [31:0] q;
		bus(0, ra(r), 0, q);
		chk(q, {12'h0, e});
	endtask
	// Poll busy so results are read only once the unit is idle
	task automatic run(input logic [31:0] c, output logic [31:0] st);
		int k;
		bus(1, `EXS_OFF_CMD, c, st);
		k = 0;
		do begin
			bus(0, `EXS_OFF_STAT, 0, st);
			k++;
		end while (st[0] !== 1'b0 && k < 200);
		// A unit still busy after the poll limit counts as a failure
		if (st[0] !== 1'b0) n_fail++;
	endtask
	task automatic t_multi();
		logic [31:0] st;
		logic [19:0] v;
		wreg(ra(2), 32'h0000_013F);
		wreg(ra(1), 32'h0000_0200);
		for (int i = 4; i < 8; i++) wreg(ra(i), pv(i));
		run(cm(OP_MPUSH, SZ_A, M_REG, 3, 6), st);
		for (int i = 0; i < 3; i++) begin
			v = pv(6 - i);
			chk(mw(20'h1FC - 20'(4 * i)), v[15:0]);
			chk(mw(20'h1FE - 20'(4 * i)), {12'h0, v[19:16]});
			ckr(6 - i, v);
		end
		ckr(1, 20'h0_01F4);
		ckr(2, 20'h0_013F);
		slow <= 1;
		run(cm(OP_MPOP, SZ_A, M_REG, 3, 11), st);
		for (int i = 0; i < 3; i++) ckr(9 + i, pv(4 + i));
		ckr(1, 20'h0_0200);
		ckr(2, 20'h0_013F);
		run(cm(OP_MPUSH, SZ_W, M_REG, 2, 10), st);
		ckr(1, 20'h0_01FC);
		v = pv(5);
		chk(mw(20'h1FE), v[15:0]);
		run(cm(OP_MPOP, SZ_W, M_REG, 2, 13), st);
		slow <= 0;
		for (int i = 0; i < 2; i++) ckr(12 + i, {4'h0, 16'h5A00 | 16'(4 + i)});
		ckr(1, 20'h0_0200);
	endtask
	task automatic t_single();
		logic [31:0] st;
		logic [19:0] v;
		v = pv(7);
		run(cm(OP_SPUSH, SZ_A, M_REG, 1, 7), st);
		ckr(1, 20'h0_01FC);
		chk({mw(20'h1FE), mw(20'h1FC)}, {12'h0, v});
		run(cm(OP_SPOP, SZ_A, M_REG, 1, 12), st);
		ckr(12, v);
		ckr(1, 20'h0_0200);
		run(cm(OP_SPUSH, SZ_B, M_REG, 1, 7), st);
		ckr(1, 20'h0_01FE);
		wreg(`EXS_OFF_OPND, 32'h0000_0300);
		run(cm(OP_SPOP, SZ_W, M_ABS, 1, 0), st);
		chk(mw(20'h300), {8'h00, v[7:0]});
		ckr(1, 20'h0_0200);
		ckr(2, 20'h0_013F);
	endtask
	task automatic t_mshift();
		logic [31:0] st;
		logic [19:0] x, r;
		logic c;
		for (int k = 0; k < 2; k++) for (int s = 0; s < 2; s++) for (int n = 1; n < 5; n++) begin
			x = k ? 20'h8_0000 : 20'hA_5C3B;
			r = s ? (x << n) : {4'h0, 16'(x[15:0] << n)};
			c = s ? x[20 - n] : x[16 - n];
			wreg(ra(14), x);
			wreg(ra(2), 32'h0000_0138);
			run(cm(OP_MSHIFT, s ? SZ_A : SZ_W, M_REG, n, 14), st);
			ckr(14, r);
			bus(0, ra(2), 0, st);
			chk(st[5:0], {3'b111, s ? r[19] : r[15], r == 0, c});
		end
	endtask
	task automatic t_shx();
		logic [31:0] st, x, r, m, lo, hi;
		int w;
		for (int s = 0; s < 3; s++) for (int j = 0; j < 4; j++) begin
			w = s == 0 ? 16 : s == 1 ? 8 : 20;
			lo = s == 0 ? `EXS_OVF_W_LO : s == 1 ? `EXS_OVF_B_LO : `EXS_OVF_A_LO;
			hi = s == 0 ? `EXS_OVF_W_HI : s == 1 ? `EXS_OVF_B_HI : `EXS_OVF_A_HI;
			x = j[1] ? hi - j[0] : lo - !j[0];
			m = (32'h1 << w) - 1;
			r = (x << 1) & m;
			wreg(ra(15), x);
			wreg(ra(2), 32'h0000_0038);
			run(cm(OP_SHIFTX, exs_size_t'(s), M_REG, 1, 15), st);
			bus(0, ra(15), 0, st);
			chk(st & m, r);
			bus(0, ra(2), 0, st);
			chk({st[8], st[5:0]}, {x >= lo && x < hi, 3'b111, r[w - 1], r == 0, x[w - 1]});
		end
	endtask
	task automatic t_amove();
		logic [31:0] st;
		logic [19:0] v;
		v = pv(3);
		wreg(ra(3), v);
		wreg(ra(10), 32'h0000_0400);
		// Minus two as a 20-bit index, so it fits a signed 16-bit index
		wreg(`EXS_OFF_OPND, 32'h000F_FFFE);
		run(cm(OP_AMOVE, SZ_A, M_IDX, 1, 3, 10), st);
		chk(st[2], 1'b1);
		chk({mw(20'h400), mw(20'h3FE)}, {12'h0, v});
	endtask
	// Memory operand paths: shift in place, push from memory, byte pop to register
	task automatic t_shmem();
		logic [31:0] st;
		wreg(ra(2), 32'h0000_0038);
		wreg(`EXS_OFF_OPND, 32'h0000_03FE);
		run(cm(OP_SHIFTX, SZ_W, M_ABS, 1, 0), st);
		chk(mw(20'h3FE), 16'hB406);
		bus(0, ra(2), 0, st);
		chk({st[8], st[5:0]}, 7'b111_1100);
		run(cm(OP_SPUSH, SZ_W, M_ABS, 1, 0), st);
		ckr(1, 20'h0_01FE);
		chk(mw(20'h1FE), 16'hB406);
		run(cm(OP_SPOP, SZ_B, M_REG, 1, 5), st);
		ckr(5, 20'h0_0006);
		ckr(1, 20'h0_0200);
		ckr(2, 20'h0_013C);
	endtask
	initial begin
		repeat (10) @(posedge clock);
		rst_n <= 1;
		repeat (3) @(posedge clock);
		t_multi();
		t_single();
		t_mshift();
		t_shx();
		t_amove();
		t_shmem();
		wrap_up();
	end
endmodule
